// File: logic/gmb_pkg.sv
// Constants shared by the gripper register bank and its checksum unit
package gmb_pkg;

   // ---------------------------------------------------------------
   // Register addresses (16-bit protocol addresses)
   // ---------------------------------------------------------------
   localparam logic [15:0] REG_INIT_CMD = 16'h0100;
   localparam logic [15:0] REG_GRIP_FORCE = 16'h0101;
   localparam logic [15:0] REG_TARGET_POS = 16'h0103;
   localparam logic [15:0] REG_MOVE_SPEED = 16'h0104;
   localparam logic [15:0] REG_INIT_DONE = 16'h0200;
   localparam logic [15:0] REG_MOTION_STATE = 16'h0201;
   localparam logic [15:0] REG_ACTUAL_POS = 16'h0202;
   localparam logic [15:0] REG_SAVE_FLASH = 16'h0300;
   localparam logic [15:0] REG_HOME_DIR = 16'h0301;
   localparam logic [15:0] REG_NODE_ADDR = 16'h0302;
   localparam logic [15:0] REG_RATE_CODE = 16'h0303;

   // ---------------------------------------------------------------
   // Function codes and frame fields
   // ---------------------------------------------------------------
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [7:0] FC_WRITE_ONE = 8'h06;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] BYTE_COUNT_ONE = 8'h02;
   localparam logic [15:0] QTY_ONE = 16'h0001;
   localparam logic [3:0] LEN_SHORT = 4'h8;
   localparam logic [3:0] LEN_MULTI = 4'hB;
   localparam logic [2:0] LEN_ECHO = 3'h6;
   localparam logic [2:0] LEN_READ = 3'h5;

   // ---------------------------------------------------------------
   // Command codes and legal ranges
   // ---------------------------------------------------------------
   localparam logic [15:0] INIT_HOME = 16'h0001;
   localparam logic [15:0] INIT_FULL = 16'h00A5;
   localparam logic [15:0] SAVE_GO = 16'h0001;
   localparam logic [15:0] FORCE_MIN = 16'h0014;
   localparam logic [15:0] FORCE_MAX = 16'h0064;
   localparam logic [15:0] POS_MAX = 16'h03E8;
   localparam logic [15:0] SPEED_MIN = 16'h0001;
   localparam logic [15:0] SPEED_MAX = 16'h0064;
   localparam logic [15:0] NODE_MIN = 16'h0001;
   localparam logic [15:0] NODE_MAX = 16'h00F7;
   localparam logic [15:0] RATE_MAX = 16'h0005;
   localparam logic [15:0] DIR_MAX = 16'h0001;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] FORCE_RST = 16'h0064;
   localparam logic [15:0] TARGET_RST = 16'h0000;
   localparam logic [15:0] SPEED_RST = 16'h0064;
   localparam logic DIR_RST = 1'b0;
   localparam logic [7:0] NODE_RST = 8'h01;
   localparam logic [2:0] RATE_RST = 3'h0;

   // ---------------------------------------------------------------
   // Checksum
   // ---------------------------------------------------------------
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   // ---------------------------------------------------------------
   // Timing: least length of a flash save
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int SAVE_MIN_MS = 1000;
   localparam int SAVE_CYCLES = (CLK_HZ / 1000) * SAVE_MIN_MS;

endpackage

// File: logic/gmb_crc16_byte.sv
// One-byte update of the 16-bit frame checksum
`timescale 1ns/100ps
`default_nettype none

module gmb_crc16_byte (
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [15:0] crc_out
);

   // ---------------------------------------------------------------
   // Reflected shift, eight bits, low bit first
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] c;
      c = crc_in ^ {8'h00, data_in};
      for (int i = 0; i < 8; i++) begin
         if (c[0]) begin
            c = (c >> 1) ^ gmb_pkg::CRC_POLY;
         end else begin
            c = c >> 1;
         end
      end
      crc_out = c;
   end

endmodule
`default_nettype wire

// File: logic/gmb_reg_bank.sv
// Serial-bus holding register bank of the gripper
`timescale 1ns/100ps
`default_nettype none

module gmb_reg_bank #(
   parameter int SAVE_CYCLES = gmb_pkg::SAVE_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_VALID,
   input wire logic RX_GAP,
   input wire logic TX_READY,
   output logic [7:0] TX_BYTE,
   output logic TX_VALID,
   input wire logic HOME_BUSY,
   input wire logic HOME_OK,
   input wire logic [1:0] GRIP_STATE,
   input wire logic [15:0] ACT_POS,
   input wire logic FLASH_DONE,
   output logic HOME_START,
   output logic HOME_FULL,
   output logic HOME_DIR,
   output logic MOVE_START,
   output logic [15:0] FORCE_PCT,
   output logic [15:0] TARGET_POS,
   output logic [15:0] SPEED_PCT,
   output logic [7:0] NODE_ADDR,
   output logic [2:0] RATE_CODE,
   output logic FLASH_SAVE
);

   // ---------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      GMB_RX = 2'b00,   // Collecting a frame
      GMB_SAVE = 2'b01, // Waiting for flash save to end
      GMB_TX = 2'b10    // Sending the reply
   } gmb_phase_t;

   typedef struct packed {
      gmb_phase_t ph;
      logic [10:0][7:0] rx;   // Received bytes
      logic [3:0] rx_cnt;     // Bytes received so far
      logic rx_over;          // Frame longer than any we serve
      logic [15:0] rx_crc;    // Running checksum of the frame
      logic [5:0][7:0] tx;    // Reply body, checksum excluded
      logic [2:0] tx_len;
      logic [2:0] tx_idx;
      logic [15:0] tx_crc;
      logic [7:0] tx_byte;
      logic tx_stb;
      logic [15:0] force_v;
      logic [15:0] target;
      logic [15:0] speed;
      logic dir;
      logic [7:0] node;
      logic [2:0] rate;
      logic home_start;
      logic home_full;
      logic move_start;
      logic save_req;
      logic [31:0] save_cnt;  // Cycles spent in the save
      logic flash_seen;       // Flash finished while counting
   } gmb_state_t;

   gmb_state_t s_q;
   gmb_state_t s_d;

   // ---------------------------------------------------------------
   // Checksum units: one for receive, one for reply
   // ---------------------------------------------------------------
   logic [15:0] rx_crc_next;
   logic [15:0] tx_crc_next;
   logic [7:0] tx_body_byte;

   gmb_crc16_byte u_rx_crc (
      .crc_in(s_q.rx_crc),
      .data_in(RX_BYTE),
      .crc_out(rx_crc_next)
   );

   gmb_crc16_byte u_tx_crc (
      .crc_in(s_q.tx_crc),
      .data_in(tx_body_byte),
      .crc_out(tx_crc_next)
   );

   // Body byte at the reply index; zero past the body
   always_comb begin
      if (s_q.tx_idx < s_q.tx_len) begin
         tx_body_byte = s_q.tx[s_q.tx_idx];
      end else begin
         tx_body_byte = 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   logic [7:0] fc;
   logic [15:0] reg_a;
   logic [15:0] qty;
   logic [15:0] wval;
   logic is_read;
   logic is_write;
   logic frame_ok;
   logic [15:0] rd_val;

   always_comb begin
      fc = s_q.rx[1];
      reg_a = {s_q.rx[2], s_q.rx[3]};
      qty = {s_q.rx[4], s_q.rx[5]};
      is_read = (fc == gmb_pkg::FC_READ_HOLD) ||
                (fc == gmb_pkg::FC_READ_INPUT);
      is_write = 1'b0;
      wval = {s_q.rx[4], s_q.rx[5]};
      if (fc == gmb_pkg::FC_WRITE_ONE) begin
         is_write = (s_q.rx_cnt == gmb_pkg::LEN_SHORT);
      end else if (fc == gmb_pkg::FC_WRITE_MULTI) begin
         // Only a one-register block write is served
         wval = {s_q.rx[7], s_q.rx[8]};
         is_write = (s_q.rx_cnt == gmb_pkg::LEN_MULTI) &&
                    (qty == gmb_pkg::QTY_ONE) &&
                    (s_q.rx[6] == gmb_pkg::BYTE_COUNT_ONE);
      end
      is_read = is_read && (s_q.rx_cnt == gmb_pkg::LEN_SHORT) &&
                (qty == gmb_pkg::QTY_ONE);
      // Bad checksum, foreign address or odd shape: silently dropped
      frame_ok = !s_q.rx_over && (s_q.rx_crc == gmb_pkg::CRC_RESIDUE) &&
                 (s_q.rx[0] == s_q.node) &&
                 (is_read || is_write);
   end

   // Read value by address; unmapped and reserved read zero
   always_comb begin
      case (reg_a)
         gmb_pkg::REG_INIT_CMD: rd_val = {15'h0000, HOME_BUSY};
         gmb_pkg::REG_GRIP_FORCE: rd_val = s_q.force_v;
         gmb_pkg::REG_TARGET_POS: rd_val = s_q.target;
         gmb_pkg::REG_MOVE_SPEED: rd_val = s_q.speed;
         gmb_pkg::REG_INIT_DONE: rd_val = {15'h0000, HOME_OK};
         // Motion side encodes 0..3 incl. dropped-object case
         gmb_pkg::REG_MOTION_STATE: begin
            rd_val = {14'h0000, GRIP_STATE};
         end
         gmb_pkg::REG_ACTUAL_POS: rd_val = ACT_POS;
         gmb_pkg::REG_SAVE_FLASH: rd_val = 16'h0000;
         gmb_pkg::REG_HOME_DIR: rd_val = {15'h0000, s_q.dir};
         gmb_pkg::REG_NODE_ADDR: rd_val = {8'h00, s_q.node};
         gmb_pkg::REG_RATE_CODE: rd_val = {13'h0000, s_q.rate};
         default: rd_val = 16'h0000;
      endcase
   end

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Command strobes last one cycle
      s_d.home_start = 1'b0;
      s_d.move_start = 1'b0;
      s_d.save_req = 1'b0;
      s_d.tx_stb = 1'b0;
      case (s_q.ph)
         GMB_RX: begin
            if (RX_GAP) begin
               // Silence closes the frame; a byte in this cycle is lost
               s_d.rx_cnt = 4'h0;
               s_d.rx_over = 1'b0;
               s_d.rx_crc = gmb_pkg::CRC_INIT;
               s_d.tx_idx = 3'h0;
               s_d.tx_crc = gmb_pkg::CRC_INIT;
               if (frame_ok) begin
                  s_d.ph = GMB_TX;
                  // Write reply echoes the first six bytes
                  s_d.tx = s_q.rx[5:0];
                  s_d.tx_len = gmb_pkg::LEN_ECHO;
                  if (is_read) begin
                     s_d.tx[2] = gmb_pkg::BYTE_COUNT_ONE;
                     s_d.tx[3] = rd_val[15:8];
                     s_d.tx[4] = rd_val[7:0];
                     s_d.tx_len = gmb_pkg::LEN_READ;
                  end else begin
                     // Out-of-range values are echoed but not stored
                     case (reg_a)
                        gmb_pkg::REG_INIT_CMD: begin
                           // Master is trusted to home first
                           if (wval == gmb_pkg::INIT_HOME) begin
                              s_d.home_start = 1'b1;
                              s_d.home_full = 1'b0;
                           end else if (wval == gmb_pkg::INIT_FULL) begin
                              s_d.home_start = 1'b1;
                              s_d.home_full = 1'b1;
                           end
                        end
                        gmb_pkg::REG_GRIP_FORCE: begin
                           if (wval >= gmb_pkg::FORCE_MIN &&
                               wval <= gmb_pkg::FORCE_MAX) begin
                              s_d.force_v = wval;
                           end
                        end
                        gmb_pkg::REG_TARGET_POS: begin
                           if (wval <= gmb_pkg::POS_MAX) begin
                              s_d.target = wval;
                              s_d.move_start = 1'b1;
                           end
                        end
                        gmb_pkg::REG_MOVE_SPEED: begin
                           if (wval >= gmb_pkg::SPEED_MIN &&
                               wval <= gmb_pkg::SPEED_MAX) begin
                              s_d.speed = wval;
                           end
                        end
                        gmb_pkg::REG_SAVE_FLASH: begin
                           if (wval == gmb_pkg::SAVE_GO) begin
                              // Reply held until the save ends
                              s_d.save_req = 1'b1;
                              s_d.save_cnt = 32'h0000_0000;
                              s_d.flash_seen = 1'b0;
                              s_d.ph = GMB_SAVE;
                           end
                        end
                        gmb_pkg::REG_HOME_DIR: begin
                           if (wval <= gmb_pkg::DIR_MAX) begin
                              s_d.dir = wval[0];
                           end
                        end
                        gmb_pkg::REG_NODE_ADDR: begin
                           if (wval >= gmb_pkg::NODE_MIN &&
                               wval <= gmb_pkg::NODE_MAX) begin
                              s_d.node = wval[7:0];
                           end
                        end
                        gmb_pkg::REG_RATE_CODE: begin
                           if (wval <= gmb_pkg::RATE_MAX) begin
                              s_d.rate = wval[2:0];
                           end
                        end
                        default: begin
                        end
                     endcase
                  end
               end
            end else if (RX_VALID) begin
               // Store while room; longer frames are marked bad
               if (s_q.rx_cnt < gmb_pkg::LEN_MULTI) begin
                  s_d.rx[s_q.rx_cnt] = RX_BYTE;
                  s_d.rx_cnt = s_q.rx_cnt + 4'h1;
               end else begin
                  s_d.rx_over = 1'b1;
               end
               s_d.rx_crc = rx_crc_next;
            end
         end
         GMB_SAVE: begin
            // Frames arriving now are not even collected
            s_d.flash_seen = s_q.flash_seen | FLASH_DONE;
            if (s_q.save_cnt < SAVE_CYCLES - 1) begin
               s_d.save_cnt = s_q.save_cnt + 32'h0000_0001;
            end else if (s_q.flash_seen || FLASH_DONE) begin
               s_d.ph = GMB_TX;
            end
         end
         GMB_TX: begin
            // One byte per ready cycle, idle cycle between bytes
            if (TX_READY && !s_q.tx_stb) begin
               s_d.tx_stb = 1'b1;
               s_d.tx_idx = s_q.tx_idx + 3'h1;
               if (s_q.tx_idx < s_q.tx_len) begin
                  s_d.tx_byte = tx_body_byte;
                  s_d.tx_crc = tx_crc_next;
               end else if (s_q.tx_idx == s_q.tx_len) begin
                  s_d.tx_byte = s_q.tx_crc[7:0];
               end else begin
                  s_d.tx_byte = s_q.tx_crc[15:8];
                  s_d.ph = GMB_RX;
               end
            end
         end
         default: begin
            s_d.ph = GMB_RX;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_q <= '0;
         s_q.ph <= GMB_RX;
         s_q.rx_crc <= gmb_pkg::CRC_INIT;
         s_q.tx_crc <= gmb_pkg::CRC_INIT;
         s_q.force_v <= gmb_pkg::FORCE_RST;
         s_q.target <= gmb_pkg::TARGET_RST;
         s_q.speed <= gmb_pkg::SPEED_RST;
         s_q.dir <= gmb_pkg::DIR_RST;
         s_q.node <= gmb_pkg::NODE_RST;
         s_q.rate <= gmb_pkg::RATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign TX_BYTE = s_q.tx_byte;
   assign TX_VALID = s_q.tx_stb;
   assign HOME_START = s_q.home_start;
   assign HOME_FULL = s_q.home_full;
   assign HOME_DIR = s_q.dir;
   assign MOVE_START = s_q.move_start;
   assign FORCE_PCT = s_q.force_v;
   assign TARGET_POS = s_q.target;
   assign SPEED_PCT = s_q.speed;
   assign NODE_ADDR = s_q.node;
   assign RATE_CODE = s_q.rate;
   assign FLASH_SAVE = s_q.save_req;

endmodule
`default_nettype wire

// File: tb/gmb_reg_bank_chk.sv
// Port assertions for the gripper register bank
`timescale 1ns/100ps
`default_nettype none
module gmb_reg_bank_chk #(
   parameter int SAVE_CYCLES = 20
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic TX_VALID,
   input wire logic HOME_START,
   input wire logic MOVE_START,
   input wire logic FLASH_SAVE,
   input wire logic [15:0] FORCE_PCT,
   input wire logic [15:0] TARGET_POS,
   input wire logic [15:0] SPEED_PCT,
   input wire logic [7:0] NODE_ADDR,
   input wire logic [2:0] RATE_CODE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   int save_cnt_q; // Cycles since the last save began, saturating
   // ----------------------------------------
   // Save age counter
   // ----------------------------------------
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         save_cnt_q <= SAVE_CYCLES;
      end else if (FLASH_SAVE) begin
         save_cnt_q <= 0;
      end else if (save_cnt_q < SAVE_CYCLES) begin
         save_cnt_q <= save_cnt_q + 1;
      end
   end
   // No reply, home or move strobe leaves the block for eight cycles after a save starts
   sequence s_quiet;
      (!TX_VALID && !HOME_START && !MOVE_START) [*8];
   endsequence
   a_tx_single: assert property (TX_VALID |=> !TX_VALID)
      else $error("reply strobe too long");
   a_home_single: assert property (HOME_START |=> !HOME_START)
      else $error("home start too long");
   a_move_single: assert property (MOVE_START |=> !MOVE_START)
      else $error("move start too long");
   a_save_single: assert property (FLASH_SAVE |=> !FLASH_SAVE)
      else $error("save strobe too long");
   a_save_quiet: assert property (FLASH_SAVE |=> s_quiet)
      else $error("activity during save");
   a_save_wait: assert property (
      TX_VALID |-> save_cnt_q >= SAVE_CYCLES)
      else $error("save reply early");
   a_force_range: assert property (FORCE_PCT inside {[20:100]})
      else $error("force out of range");
   a_speed_range: assert property (SPEED_PCT inside {[1:100]})
      else $error("speed out of range");
   a_target_range: assert property (TARGET_POS <= 16'h03E8)
      else $error("target out of range");
   a_node_range: assert property (NODE_ADDR inside {[1:247]})
      else $error("node out of range");
   a_rate_range: assert property (RATE_CODE <= 3'h5)
      else $error("rate code out of range");
endmodule
`default_nettype wire

// File: tb/gmb_master_model.sv
// Far side: reply sink with stalls, homing motion and flash
`timescale 1ns/100ps
`default_nettype none
module gmb_master_model (
   input wire logic REF_CLK,
   input wire logic [7:0] TX_BYTE,
   input wire logic TX_VALID,
   input wire logic HOME_START,
   input wire logic FLASH_SAVE,
   output logic TX_READY,
   output logic HOME_BUSY,
   output logic HOME_OK,
   output logic FLASH_DONE
);
   logic [7:0] got_q[$]; // Reply bytes in arrival order
   int cyc = 0;
   int home_left = 0;
   int save_left = 0;
   initial begin
      TX_READY = 1;
      HOME_BUSY = 0;
      HOME_OK = 0;
      FLASH_DONE = 0;
   end
   // Capture replies; start homing and flash timers
   always @(posedge REF_CLK) begin
      if (TX_VALID === 1'b1) got_q.push_back(TX_BYTE);
      // Long enough that the next frame still reads homing busy
      if (HOME_START === 1'b1) home_left = 120;
      if (FLASH_SAVE === 1'b1) save_left = 5;
   end
   // Stall one cycle in four, so the sender must really wait
   always @(negedge REF_CLK) begin
      cyc = cyc + 1;
      TX_READY = (cyc % 4) != 0;
      HOME_BUSY = home_left > 0;
      if (home_left == 1) HOME_OK = 1;
      if (home_left > 0) home_left = home_left - 1;
      FLASH_DONE = save_left == 1;
      if (save_left > 0) save_left = save_left - 1;
   end
endmodule
`default_nettype wire

// File: tb/gmb_reg_bank_test.sv
// Frame level test of the gripper register bank
`timescale 1ns/100ps
`default_nettype none
module gmb_reg_bank_test;
   logic ref_clk = 0;
   logic sys_rst, rx_valid, rx_gap, tx_ready, tx_valid, home_busy, home_ok;
   logic flash_done, home_start, home_full, home_dir, move_start, flash_save;
   logic [7:0] rx_byte, tx_byte, node_addr;
   logic [1:0] grip_state;
   logic [2:0] rate_code;
   logic [15:0] act_pos, force_pct, target_pos, speed_pct;
   logic home_seen, move_seen, save_seen; // Strobes seen in a transfer
   logic [47:0] tbl[15]; // Write address, value, value read back after
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   gmb_reg_bank #(.SAVE_CYCLES(20)) dut (.REF_CLK(ref_clk),
      .SYS_RST(sys_rst), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
      .RX_GAP(rx_gap), .TX_READY(tx_ready), .TX_BYTE(tx_byte),
      .TX_VALID(tx_valid), .HOME_BUSY(home_busy), .HOME_OK(home_ok),
      .GRIP_STATE(grip_state), .ACT_POS(act_pos),
      .FLASH_DONE(flash_done), .HOME_START(home_start),
      .HOME_FULL(home_full), .HOME_DIR(home_dir),
      .MOVE_START(move_start), .FORCE_PCT(force_pct),
      .TARGET_POS(target_pos), .SPEED_PCT(speed_pct),
      .NODE_ADDR(node_addr), .RATE_CODE(rate_code),
      .FLASH_SAVE(flash_save));
   gmb_master_model mdl (.REF_CLK(ref_clk), .TX_BYTE(tx_byte),
      .TX_VALID(tx_valid), .HOME_START(home_start),
      .FLASH_SAVE(flash_save), .TX_READY(tx_ready),
      .HOME_BUSY(home_busy), .HOME_OK(home_ok), .FLASH_DONE(flash_done));
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Latch motion and save strobes between transfers
   always @(posedge ref_clk) begin
      if (home_start === 1'b1) home_seen = 1;
      if (move_start === 1'b1) move_seen = 1;
      if (flash_save === 1'b1) save_seen = 1;
   end
   task automatic give_verdict();
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Checksum worked out here, independent of the design's unit
   function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   // One byte or one gap pulse, two cycles apart
   task automatic put(input logic [7:0] b, input logic g);
      @(negedge ref_clk);
      rx_byte = b;
      rx_valid = !g;
      rx_gap = g;
      @(negedge ref_clk);
      rx_valid = 0;
      rx_gap = 0;
   endtask
   // Mode 0 expects a reply, 1 expects none, 2 corrupts the checksum
   task automatic xfer(input logic [7:0] nd, fc, input logic [15:0] a, v,
                       input int mode);
      logic [7:0] f[$];
      logic [7:0] e[$];
      logic [15:0] c;
      home_seen = 0;
      move_seen = 0;
      save_seen = 0;
      mdl.got_q.delete();
      f = {nd, fc, a[15:8], a[7:0]};
      if (fc == 8'h10) f = {f, 8'h00, 8'h01, 8'h02, v[15:8], v[7:0]};
      else if (fc == 8'h06) f = {f, v[15:8], v[7:0]};
      else f = {f, 8'h00, 8'h01};
      c = crc_of(f);
      f = {f, c[7:0], c[15:8]};
      if (fc == 8'h06) e = f;
      else if (fc == 8'h10) e = f[0:5];
      else e = {nd, fc, 8'h02, v[15:8], v[7:0]};
      if (fc != 8'h06) begin
         c = crc_of(e);
         e = {e, c[7:0], c[15:8]};
      end
      if (mode == 2) f[f.size() - 1] = ~f[f.size() - 1];
      foreach (f[i]) put(f[i], 0);
      put(8'h00, 1);
      for (int i = 0; i < 400 && mdl.got_q.size() < e.size(); i++) begin
         @(negedge ref_clk);
      end
      repeat (30) @(negedge ref_clk);
      if (mode != 0) e.delete();
      check("reply length", mdl.got_q.size(), e.size());
      foreach (e[i]) check("reply byte", mdl.got_q[i], e[i]);
   endtask
   initial begin
      forever begin
         @(posedge ref_clk);
         cyc++;
         if (cyc == 40000) begin
            n_mismatch++;
            give_verdict();
         end
      end
   end
   initial begin
      tbl = '{{gmb_pkg::REG_GRIP_FORCE, 32'h0013_0064},
         {gmb_pkg::REG_GRIP_FORCE, 32'h0014_0014},
         {gmb_pkg::REG_GRIP_FORCE, 32'h0065_0014},
         {gmb_pkg::REG_GRIP_FORCE, 32'h001E_001E},
         {gmb_pkg::REG_MOVE_SPEED, 32'h0000_0064},
         {gmb_pkg::REG_MOVE_SPEED, 32'h0001_0001},
         {gmb_pkg::REG_MOVE_SPEED, 32'h0065_0001},
         {gmb_pkg::REG_TARGET_POS, 32'h03E9_0000},
         {gmb_pkg::REG_TARGET_POS, 32'h03E8_03E8},
         {gmb_pkg::REG_RATE_CODE, 32'h0006_0000},
         {gmb_pkg::REG_RATE_CODE, 32'h0005_0005},
         {gmb_pkg::REG_HOME_DIR, 32'h0002_0001},
         {gmb_pkg::REG_NODE_ADDR, 32'h0000_0001},
         {gmb_pkg::REG_NODE_ADDR, 32'h00F8_0001},
         {gmb_pkg::REG_SAVE_FLASH, 32'h0000_0000}};
      sys_rst = 1;
      rx_byte = 8'h00;
      rx_valid = 0;
      rx_gap = 0;
      grip_state = 2'h0;
      act_pos = 16'h0000;
      repeat (3) @(negedge ref_clk);
      sys_rst = 0;
      xfer(8'h01, 8'h03, 16'h0101, 16'h0064, 0);
      xfer(8'h01, 8'h03, 16'h0302, 16'h0001, 0);
      xfer(8'h01, 8'h03, 16'h0303, 16'h0000, 0);
      xfer(8'h01, 8'h03, 16'h0200, 16'h0000, 0);
      xfer(8'h01, 8'h03, 16'h0100, 16'h0000, 0);
      xfer(8'h01, 8'h06, 16'h0100, 16'h0001, 0);
      check("home start", home_seen, 1);
      check("home dir", {home_full, home_dir}, 0);
      xfer(8'h01, 8'h03, 16'h0100, 16'h0001, 0);
      repeat (80) @(negedge ref_clk);
      xfer(8'h01, 8'h03, 16'h0100, 16'h0000, 0);
      xfer(8'h01, 8'h03, 16'h0200, 16'h0001, 0);
      xfer(8'h01, 8'h06, 16'h0301, 16'h0001, 0);
      xfer(8'h01, 8'h06, 16'h0100, 16'h00A5, 0);
      check("full home", {home_seen, home_full, home_dir}, 7);
      xfer(8'h01, 8'h06, 16'h0100, 16'h0007, 0);
      check("no home", home_seen, 0);
      foreach (tbl[i]) begin
         xfer(8'h01, 8'h06, tbl[i][47:32], tbl[i][31:16], 0);
         xfer(8'h01, 8'h03, tbl[i][47:32], tbl[i][15:0], 0);
      end
      check("force port", force_pct, 16'h001E);
      check("speed port", speed_pct, 16'h0001);
      check("target port", target_pos, 16'h03E8);
      check("rate", rate_code, 3'h5);
      xfer(8'h01, 8'h06, 16'h0103, 16'h01F4, 0);
      check("move start", move_seen, 1);
      check("move target", target_pos, 16'h01F4);
      for (int g = 0; g < 4; g++) begin
         grip_state = g[1:0];
         xfer(8'h01, 8'h03, 16'h0201, 16'(g), 0);
      end
      act_pos = 16'h02A7;
      xfer(8'h01, 8'h03, 16'h0202, 16'h02A7, 0);
      xfer(8'h01, 8'h04, 16'h0202, 16'h02A7, 0);
      xfer(8'h01, 8'h10, 16'h0104, 16'h0032, 0);
      xfer(8'h01, 8'h03, 16'h0102, 16'h0000, 0);
      xfer(8'h01, 8'h05, 16'h0104, 16'h0000, 1);
      xfer(8'h01, 8'h06, 16'h0104, 16'h0005, 2);
      xfer(8'h01, 8'h03, 16'h0104, 16'h0032, 0);
      xfer(8'h01, 8'h06, 16'h0302, 16'h0005, 0);
      xfer(8'h01, 8'h03, 16'h0104, 16'h0032, 1);
      xfer(8'h05, 8'h03, 16'h0302, 16'h0005, 0);
      check("node", node_addr, 8'h05);
      xfer(8'h05, 8'h06, 16'h0300, 16'h0001, 0);
      check("save", save_seen, 1);
      xfer(8'h05, 8'h03, 16'h0300, 16'h0000, 0);
      give_verdict();
   end
endmodule
bind gmb_reg_bank gmb_reg_bank_chk #(.SAVE_CYCLES(SAVE_CYCLES)) chk (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .TX_VALID(TX_VALID),
   .HOME_START(HOME_START), .MOVE_START(MOVE_START),
   .FLASH_SAVE(FLASH_SAVE), .FORCE_PCT(FORCE_PCT),
   .TARGET_POS(TARGET_POS), .SPEED_PCT(SPEED_PCT),
   .NODE_ADDR(NODE_ADDR), .RATE_CODE(RATE_CODE));
`default_nettype wire
